/* File: rtl/voltage_hold.sv */
// Voltage angle hold controller with harmonic display and sync-angle validity.
//
// How it works
// - An enable control bit; when cleared the hold never engages.
// - Voltages must have been healthy over 2.5 s before engaging.
// - Every used voltage must be below the entry threshold together.
// - With the current qualifier on, one phase current must exceed pickup.
// - Engaged amplitude output is the entry threshold, whatever the live voltage.
// - Engaged angle output is the angle latched just before the fault.
// - A hold active output is high whenever the hold is engaged.
// - Blocking input is sampled at each program cycle start.
// - Engaged time is limited by a definite-time setting of 0.02 to 50.00 s.
// - On expiry values stop, protection is blocked, start and trip cleared.
// - Harmonic content is shown as percent of fundamental or absolute.
// - Harmonic display is per-unit, primary volts or secondary volts.
// - Any harmonic order 2 to 31 is reported per input at 0.01 V.
// - Sync angles are valid only in two-line-plus-sync mode with both used.
// - Angles are reported from 0.00 to 359.99 degrees in 0.01 degree steps.
// - Entry threshold is set in 0.01 percent steps, default 15.00 percent.
`default_nettype none
module voltage_hold
  import vhold_pkg::*;
#(
  parameter int PROG_CLKS = PROG_CYCLE_CLKS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire meas_t meas,
  input wire logic [2:0][15:0] phase_cur,
  input wire logic block_pin,
  input wire logic [15:0] harm_mag,
  input wire logic [15:0] fund_mag,
  output logic [4:0] harm_order,
  output logic [1:0] harm_chan,
  output hold_t hold_out,
  output logic prot_block,
  output logic start_trip_clear,
  output logic sync_ang_valid,
  output logic [9:0] event_pulse
);
  typedef enum logic [1:0] {ST_QUALIFY, ST_ENGAGED, ST_EXPIRED} state_t;

  state_t state_r;
  logic [31:0] ctrl_r;
  logic [15:0] thresh_r;
  logic [15:0] dur_r;
  logic [15:0] pickup_r;
  logic [15:0] pri_scale_r;
  logic [15:0] pu_scale_r;
  logic [31:0] harm_out_r;
  logic [19:0] prog_cnt_r;
  logic tick;
  logic block_lvl;
  logic blocked_r;
  logic [9:0] healthy_cnt_r;
  logic [16:0] hold_cnt_r;
  logic [16:0] hold_limit;
  logic [NCH-1:0][15:0] saved_ang_r;
  logic [NCH-1:0][15:0] live_ang;
  logic [NCH-1:0] below;
  logic low_all;
  logic any_low;
  logic cur_high;
  logic qualified;
  logic armed;
  logic drop;
  logic engaged;
  logic wr_en;
  logic setup;
  logic mapped;
  logic [4:0] prev_flags_r;
  logic [4:0] flags;
  logic div_done;
  logic [31:0] div_quo;
  logic [31:0] harm_scaled;

  // Clamp a written setting into its legal span.
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Decide whether an offset names a register.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = a == OFS_CTRL || a == OFS_THRESH || a == OFS_DURATION
             || a == OFS_PICKUP || a == OFS_HARM_SEL || a == OFS_STATUS
             || a == OFS_HARM_OUT || a == OFS_PRI_SCALE || a == OFS_PU_SCALE;
  endfunction

  // Fold an angle into the 0.00 to 359.99 degree span.
  function automatic logic [15:0] wrap_angle(input logic [15:0] a);
    wrap_angle = (a >= ANGLE_FULL) ? a - ANGLE_FULL : a;
  endfunction

  // The slave always answers in the first access cycle.
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign mapped = is_mapped(paddr);
  assign pslverr = psel && penable && !mapped;

  // Control and setting registers written by software.
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r <= CTRL_RESET;
      thresh_r <= THRESH_RESET;
      dur_r <= DUR_RESET;
      pickup_r <= PICKUP_RESET;
      harm_order <= HARM_ORD_MIN;
      harm_chan <= 2'h0;
      pri_scale_r <= SCALE_RESET;
      pu_scale_r <= SCALE_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: ctrl_r <= pwdata & 32'h0000_0F1F;
        OFS_THRESH: thresh_r <= clamp16(pwdata[15:0], THRESH_MIN, THRESH_MAX);
        OFS_DURATION: dur_r <= clamp16(pwdata[15:0], DUR_MIN, DUR_MAX);
        OFS_PICKUP: pickup_r <= pwdata[15:0];
        OFS_HARM_SEL: begin
          harm_order <= (pwdata[4:0] < HARM_ORD_MIN) ? HARM_ORD_MIN : pwdata[4:0];
          harm_chan <= pwdata[9:8];
        end
        OFS_PRI_SCALE: pri_scale_r <= pwdata[15:0];
        OFS_PU_SCALE: pu_scale_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle and stands through the access cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: prdata <= ctrl_r;
        OFS_THRESH: prdata <= {16'h0, thresh_r};
        OFS_DURATION: prdata <= {16'h0, dur_r};
        OFS_PICKUP: prdata <= {16'h0, pickup_r};
        OFS_HARM_SEL: prdata <= {22'h0, harm_chan, 3'h0, harm_order};
        OFS_STATUS: prdata <= {26'h0, state_r, flags[4], flags[2:0]};
        OFS_HARM_OUT: prdata <= harm_out_r;
        OFS_PRI_SCALE: prdata <= {16'h0, pri_scale_r};
        OFS_PU_SCALE: prdata <= {16'h0, pu_scale_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Program cycle divider; tick marks the start of each cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      prog_cnt_r <= 20'h0;
    end else if (prog_cnt_r == 20'(PROG_CLKS - 1)) begin
      prog_cnt_r <= 20'h0;
    end else begin
      prog_cnt_r <= prog_cnt_r + 20'h1;
    end
  end
  assign tick = prog_cnt_r == 20'h0;

  // Blocking pin arrives from outside the clock domain.
  pin_sync u_block_sync (
    .clock(clock),
    .srst(srst),
    .pin(block_pin),
    .level(block_lvl)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      blocked_r <= 1'b0;
    end else if (tick) begin
      blocked_r <= block_lvl;
    end
  end

  // Per-channel comparison against the entry threshold.
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign below[gi] = meas.used[gi] && meas.mag[gi] < thresh_r;
      assign live_ang[gi] = wrap_angle(meas.ang[gi]);
    end
  endgenerate

  assign low_all = (meas.used != '0) && (below == meas.used);
  assign any_low = below != '0;
  assign cur_high = (phase_cur[0] > pickup_r) || (phase_cur[1] > pickup_r)
                 || (phase_cur[2] > pickup_r);
  assign qualified = low_all && (!ctrl_r[CTRL_CUR_QUAL] || cur_high);
  assign armed = healthy_cnt_r > 10'(HEALTHY_CYCLES);
  assign drop = !ctrl_r[CTRL_ENABLE] || block_lvl || !qualified; // Acted on only at a tick.
  assign engaged = state_r == ST_ENGAGED;
  assign hold_limit = 17'(dur_r * DUR_TICKS_PER_STEP);

  always_ff @(posedge clock) begin
    if (srst) begin
      healthy_cnt_r <= 10'h0;
    end else if (tick) begin
      if (any_low || meas.used == '0) begin
        healthy_cnt_r <= 10'h0;
      end else if (!armed) begin
        healthy_cnt_r <= healthy_cnt_r + 10'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      saved_ang_r <= '0;
    end else if (tick && state_r == ST_QUALIFY && !any_low) begin
      saved_ang_r <= live_ang;
    end
  end

  // Hold state machine, advanced once per program cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_QUALIFY;
      hold_cnt_r <= 17'h0;
      start_trip_clear <= 1'b0;
    end else begin
      start_trip_clear <= 1'b0;
      if (tick) begin
        unique case (state_r)
          ST_QUALIFY: begin
            hold_cnt_r <= 17'h0;
            if (!drop && armed) begin
              state_r <= ST_ENGAGED;
            end
          end
          ST_ENGAGED: begin
            hold_cnt_r <= hold_cnt_r + 17'h1;
            if (drop) begin
              state_r <= ST_QUALIFY;
            end else if (hold_cnt_r + 17'h1 >= hold_limit) begin
              state_r <= ST_EXPIRED;
              start_trip_clear <= 1'b1;
            end
          end
          ST_EXPIRED: begin
            if (drop) begin
              state_r <= ST_QUALIFY;
            end
          end
        endcase
      end
    end
  end

  assign prot_block = state_r == ST_EXPIRED;
  assign sync_ang_valid = ctrl_r[CTRL_MODE_LO +: 2] == MODE_TWO_LINE_SYNC
                       && ctrl_r[CTRL_U3_USED] && ctrl_r[CTRL_U4_USED];

  // Values for the directional protection.
  always_ff @(posedge clock) begin
    if (srst) begin
      hold_out <= '0;
    end else begin
      hold_out.active <= engaged;
      for (int i = 0; i < NCH; i++) begin
        hold_out.amp[i] <= engaged ? thresh_r : meas.mag[i];
        hold_out.ang[i] <= engaged ? saved_ang_r[i] : live_ang[i];
      end
    end
  end

  // Event flags: enable, low, current high, in use, blocked.
  assign flags = {blocked_r, engaged, cur_high, low_all, ctrl_r[CTRL_ENABLE]};

  // Rising and falling edges of each flag as one-cycle event pulses.
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_flags_r <= {4'h0, CTRL_RESET[CTRL_ENABLE]};
      event_pulse <= 10'h0;
    end else begin
      prev_flags_r <= flags;
      for (int i = 0; i < 5; i++) begin
        event_pulse[2*i] <= flags[i] && !prev_flags_r[i];
        event_pulse[2*i+1] <= !flags[i] && prev_flags_r[i];
      end
    end
  end

  pct_divider u_pct (
    .clock(clock),
    .srst(srst),
    .start(tick),
    .num(32'(harm_mag) * 32'(PCT_FULL)),
    .den(fund_mag),
    .done(div_done),
    .quo(div_quo)
  );

  always_comb begin
    unique case (disp_t'(ctrl_r[CTRL_DISP_LO +: 2]))
      DISP_PU: harm_scaled = 32'(harm_mag) * 32'(pu_scale_r);
      DISP_PRI: harm_scaled = 32'(harm_mag) * 32'(pri_scale_r);
      default: harm_scaled = 32'(harm_mag);
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      harm_out_r <= 32'h0;
    end else if (ctrl_r[CTRL_HARM_ABS]) begin
      if (tick) begin
        harm_out_r <= harm_scaled;
      end
    end else if (div_done) begin
      harm_out_r <= div_quo;
    end
  end
endmodule // voltage_hold
`default_nettype wire

/* File: common/vhold_pkg.sv */
// Shared constants and carrier types for the voltage hold controller.
`default_nettype none
package vhold_pkg;
  localparam int NCH = 4;
  // Clock and program cycle timing.
  localparam longint CLK_HZ = 125_000_000;
  localparam int PROG_CYCLE_MS = 5;
  localparam int PROG_CYCLE_CLKS = int'(CLK_HZ / 1000 * PROG_CYCLE_MS);
  localparam int HEALTHY_MS = 2500;
  localparam int HEALTHY_CYCLES = (HEALTHY_MS + PROG_CYCLE_MS - 1) / PROG_CYCLE_MS;
  localparam int DUR_STEP_MS = 10;
  localparam int DUR_TICKS_PER_STEP = DUR_STEP_MS / PROG_CYCLE_MS;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_DURATION = 8'h08;
  localparam logic [7:0] OFS_PICKUP = 8'h0C;
  localparam logic [7:0] OFS_HARM_SEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_HARM_OUT = 8'h18;
  localparam logic [7:0] OFS_PRI_SCALE = 8'h1C;
  localparam logic [7:0] OFS_PU_SCALE = 8'h20;
  // Control field positions.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_CUR_QUAL = 1;
  localparam int CTRL_HARM_ABS = 2;
  localparam int CTRL_DISP_LO = 3;
  localparam int CTRL_MODE_LO = 8;
  localparam int CTRL_U3_USED = 10;
  localparam int CTRL_U4_USED = 11;
  // Reset values and setting limits.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [15:0] THRESH_RESET = 16'h05DC;
  localparam logic [15:0] THRESH_MIN = 16'h000A;
  localparam logic [15:0] THRESH_MAX = 16'h1388;
  localparam logic [15:0] DUR_RESET = 16'h05DC;
  localparam logic [15:0] DUR_MIN = 16'h0002;
  localparam logic [15:0] DUR_MAX = 16'h1388;
  localparam logic [15:0] PICKUP_RESET = 16'h0064;
  localparam logic [4:0] HARM_ORD_MIN = 5'h02;
  localparam logic [4:0] HARM_ORD_MAX = 5'h1F;
  localparam logic [15:0] SCALE_RESET = 16'h0001;
  localparam logic [15:0] ANGLE_FULL = 16'h8CA0;
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [1:0] MODE_TWO_LINE_SYNC = 2'h2;
  typedef enum logic [1:0] {DISP_PU, DISP_PRI, DISP_SEC} disp_t;
  // Live voltage measurements of one program cycle.
  typedef struct packed {
    logic [NCH-1:0] used;
    logic [NCH-1:0][15:0] mag;
    logic [NCH-1:0][15:0] ang;
  } meas_t;
  // Values handed to the directional protection.
  typedef struct packed {
    logic active;
    logic [NCH-1:0][15:0] amp;
    logic [NCH-1:0][15:0] ang;
  } hold_t;
endpackage
`default_nettype wire

/* File: rtl/pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module pin_sync
  import vhold_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic pin,
  output logic level
);
  logic [2:0] stage_r;

  // Shift the pin through three flops; stage one feeds only stage two.
  always_ff @(posedge clock) begin
    if (srst) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= {stage_r[1:0], pin};
    end
  end

  // Hold the level until the two later stages agree.
  always_ff @(posedge clock) begin
    if (srst) begin
      level <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      level <= stage_r[2];
    end
  end
endmodule // pin_sync
`default_nettype wire

/* File: rtl/pct_divider.sv */
// Iterative unsigned divider used for harmonic percentage figures.
`default_nettype none
module pct_divider
  import vhold_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic [31:0] num,
  input wire logic [15:0] den,
  output logic done,
  output logic [31:0] quo
);
  logic [31:0] q_r;
  logic [16:0] rem_r;
  logic [5:0] cnt_r;
  logic [15:0] den_r;
  logic [16:0] trial;

  assign trial = {rem_r[15:0], q_r[31]} - {1'b0, den_r};

  // One quotient bit per clock; a zero divisor saturates the result.
  always_ff @(posedge clock) begin
    if (srst) begin
      q_r <= 32'h0;
      rem_r <= 17'h0;
      cnt_r <= 6'h0;
      den_r <= 16'h0;
      done <= 1'b0;
      quo <= 32'h0;
    end else begin
      done <= 1'b0;
      if (start && cnt_r == 6'h0) begin
        q_r <= num;
        rem_r <= 17'h0;
        den_r <= den;
        cnt_r <= 6'h20;
      end else if (cnt_r != 6'h0) begin
        cnt_r <= cnt_r - 6'h01;
        if (!trial[16]) begin
          rem_r <= trial;
          q_r <= {q_r[30:0], 1'b1};
        end else begin
          rem_r <= {rem_r[15:0], q_r[31]};
          q_r <= {q_r[30:0], 1'b0};
        end
        if (cnt_r == 6'h01) begin
          done <= 1'b1;
          quo <= (den_r == 16'h0) ? 32'hFFFF_FFFF : (!trial[16] ? {q_r[30:0], 1'b1}
                                                             : {q_r[30:0], 1'b0});
        end
      end
    end
  end
endmodule // pct_divider
`default_nettype wire

/* File: testbench/voltage_hold_monitor.sv */
// Port-level assertion checker for the voltage hold controller.
`default_nettype none
module voltage_hold_monitor
  import vhold_pkg::*;
#(
  parameter int PROG_CLKS = PROG_CYCLE_CLKS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire meas_t meas,
  input wire logic [2:0][15:0] phase_cur,
  input wire logic block_pin,
  input wire logic [15:0] harm_mag,
  input wire logic [15:0] fund_mag,
  input wire logic [4:0] harm_order,
  input wire logic [1:0] harm_chan,
  input wire hold_t hold_out,
  input wire logic prot_block,
  input wire logic start_trip_clear,
  input wire logic sync_ang_valid,
  input wire logic [9:0] event_pulse
);
  logic [7:0] blk_cnt_r;

  // Counts the clocks for which the blocking pin has stayed high.
  always_ff @(posedge clock) begin
    if (srst || !block_pin) begin
      blk_cnt_r <= 8'h00;
    end else if (blk_cnt_r != 8'hFF) begin
      blk_cnt_r <= blk_cnt_r + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // The two phases of one bus transfer.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_zero_wait: assert property (s_setup ##1 s_access |-> pready)
    else $error("access phase not answered at once");
  a_unmapped_err: assert property (s_access ##0 (paddr >= 8'h24) |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (s_access ##0 (paddr <= 8'h20 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped access flagged as error");
  a_order_floor: assert property (harm_order >= HARM_ORD_MIN)
    else $error("harmonic order below two");
  a_clear_pulse: assert property (start_trip_clear |=> !start_trip_clear)
    else $error("clear pulse longer than one clock");
  a_clear_blocks: assert property (start_trip_clear |-> ##[0:2] prot_block)
    else $error("expiry without protection block");
  a_expired_idle: assert property (prot_block && $past(prot_block) |-> !hold_out.active)
    else $error("values supplied after expiry");
  a_block_drops: assert property (blk_cnt_r > PROG_CLKS + 6 |-> !hold_out.active)
    else $error("hold stays engaged while blocked");
  a_frozen_values: assert property (hold_out.active && $past(hold_out.active)
    |-> $stable(hold_out.amp) && $stable(hold_out.ang))
    else $error("held values changed while engaged");
  a_active_event: assert property (event_pulse[6] |-> ##[0:2] hold_out.active)
    else $error("hold in use event without active output");
  a_event_single: assert property (|event_pulse[9:2] |=> event_pulse[9:2] == 8'h00)
    else $error("event pulse longer than one clock");
  c_engaged: cover property ($rose(hold_out.active));
endmodule // voltage_hold_monitor

bind voltage_hold voltage_hold_monitor #(.PROG_CLKS(PROG_CLKS)) voltage_hold_monitor_inst (
  .clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .meas(meas), .phase_cur(phase_cur), .block_pin(block_pin), .harm_mag(harm_mag),
  .fund_mag(fund_mag), .harm_order(harm_order), .harm_chan(harm_chan),
  .hold_out(hold_out), .prot_block(prot_block), .start_trip_clear(start_trip_clear),
  .sync_ang_valid(sync_ang_valid), .event_pulse(event_pulse));
`default_nettype wire

/* File: testbench/voltage_hold_tb.sv */
// Self-checking testbench for the voltage hold controller.
`default_nettype none
module voltage_hold_tb
  import vhold_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 20;
  localparam int LIMIT = 60000;
  localparam logic [3:0][15:0] ANG = {16'h8C9F, 16'h4650, 16'h2328, 16'h0064};
  localparam logic [4:0][11:0] SYNCS = {12'hF01, 12'hD01, 12'hA01, 12'h601, 12'hE01};
  logic clock;
  logic srst;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  meas_t meas;
  logic [2:0][15:0] phase_cur;
  logic block_pin;
  logic [15:0] harm_mag;
  logic [15:0] fund_mag;
  logic [4:0] harm_order;
  logic [1:0] harm_chan;
  hold_t hold_out;
  logic prot_block;
  logic start_trip_clear;
  logic sync_ang_valid;
  logic [9:0] event_pulse;
  logic stc_seen;
  logic [31:0] q;
  logic e;
  int miscompares;
  int cmp_count;
  int cyc;

  voltage_hold #(.PROG_CLKS(P)) voltage_hold_inst (
    .clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .meas(meas), .phase_cur(phase_cur), .block_pin(block_pin), .harm_mag(harm_mag),
    .fund_mag(fund_mag), .harm_order(harm_order), .harm_chan(harm_chan),
    .hold_out(hold_out), .prot_block(prot_block), .start_trip_clear(start_trip_clear),
    .sync_ang_valid(sync_ang_valid), .event_pulse(event_pulse));

  // Free-running clock of 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Notes any expiry pulse and cuts a hung run short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (start_trip_clear === 1'b1) begin
      stc_seen <= 1'b1;
    end
    if (cyc == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * P) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic volts(input logic [15:0] m, input logic [15:0] c);
    @(posedge clock);
    meas.mag <= {4{m}};
    phase_cur[0] <= c;
  endtask

  // Healthy period, then a collapse of all voltages with the given current.
  task automatic qualify(input logic [31:0] ctrl, input logic [15:0] c);
    wr(OFS_CTRL, ctrl);
    volts(16'h2710, 16'h0000);
    meas.ang <= ANG;
    ticks(HEALTHY_CYCLES + 8);
    volts(16'h0000, c);
    meas.ang <= '0;
    ticks(3);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    {psel, penable, pwrite, block_pin, stc_seen} = 5'h00;
    {paddr, pwdata, harm_mag, fund_mag} = {8'h00, 32'h0, 16'h01F4, 16'h03E8};
    meas.used = 4'hF;
    meas.mag = {4{16'h2710}};
    meas.ang = ANG;
    phase_cur = '0;
    {miscompares, cmp_count, cyc} = {32'd0, 32'd0, 32'd0};
    srst = 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    chk({27'h0, harm_order}, {27'h0, HARM_ORD_MIN});
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_THRESH, {16'h0, THRESH_RESET});
    rd(OFS_DURATION, {16'h0, DUR_RESET});
    rd(OFS_PICKUP, {16'h0, PICKUP_RESET});
    wr(OFS_THRESH, 32'h0);
    rd(OFS_THRESH, {16'h0, THRESH_MIN});
    wr(OFS_DURATION, 32'hFFFF);
    rd(OFS_DURATION, {16'h0, DUR_MAX});
    wr(OFS_THRESH, 32'h07D0);
    rd(OFS_THRESH, 32'h07D0);
    apb(1'b1, 8'h24, 32'hFFFF, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h24, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(OFS_HARM_SEL, 32'h0301);
    @(negedge clock);
    chk({25'h0, harm_chan, harm_order}, 32'h62);
    wr(OFS_HARM_SEL, 32'h001F);
    @(negedge clock);
    chk({25'h0, harm_chan, harm_order}, 32'h1F);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, {20'h0, SYNCS[i]});
      @(negedge clock);
      chk({31'h0, sync_ang_valid}, {31'h0, i == 0});
    end
    $display("sync validity test done");
    wr(OFS_PRI_SCALE, 32'h3);
    for (int d = 0; d < 3; d++) begin
      wr(OFS_CTRL, 32'(5 + 8 * d));
      ticks(3);
      rd(OFS_HARM_OUT, (d == 1) ? 32'h05DC : 32'h01F4);
    end
    wr(OFS_CTRL, 32'h11);
    ticks(3);
    rd(OFS_HARM_OUT, 32'h1388);
    $display("harmonic test done");
    qualify(32'h0, 16'h0000);
    chk({31'h0, hold_out.active}, 32'h0);
    qualify(32'h3, 16'h0000);
    chk({31'h0, hold_out.active}, 32'h0);
    wr(OFS_DURATION, 32'h64);
    qualify(32'h3, 16'h00C8);
    chk({30'h0, hold_out.active, prot_block}, 32'h2);
    for (int i = 0; i < NCH; i++) begin
      chk({16'h0, hold_out.amp[i]}, 32'h07D0);
      chk({16'h0, hold_out.ang[i]}, {16'h0, ANG[i]});
    end
    rd(OFS_STATUS, 32'h17);
    @(posedge clock);
    block_pin <= 1'b1;
    ticks(2);
    chk({31'h0, hold_out.active}, 32'h0);
    @(posedge clock);
    block_pin <= 1'b0;
    $display("engage and block test done");
    wr(OFS_DURATION, 32'h1);
    rd(OFS_DURATION, {16'h0, DUR_MIN});
    qualify(32'h1, 16'h0000);
    chk({31'h0, hold_out.active}, 32'h1);
    ticks(4);
    chk({29'h0, prot_block, hold_out.active, stc_seen}, 32'h5);
    rd(OFS_STATUS, 32'h23);
    volts(16'h2710, 16'h0000);
    ticks(2);
    chk({31'h0, prot_block}, 32'h0);
    volts(16'h0000, 16'h0000);
    ticks(3);
    chk({31'h0, hold_out.active}, 32'h0);
    $display("expiry test done");
    complete_run();
  end
endmodule // voltage_hold_tb
`default_nettype wire
